// [design/sim_interlock_top.sv]
/*
 * Safety interlock monitor: watches the redundant door and stop channels,
 * latches door-open and teach conditions, drives hold, power prohibit,
 * stop indicator and critical error, and offers a small register port.
 * Assumes connector inputs are asynchronous levels, closed contact = 1,
 * and the register master lives on core_clk.
 */
module sim_interlock_top #(
	parameter int DISC_CYCLES = sim_pkg::DISC_CYCLES,
	parameter int CNT_W       = sim_pkg::CNT_W
) (
	// Clock and reset
	input  wire logic                       core_clk,
	input  wire logic                       arst_n,
	// Register port
	input  wire logic [sim_pkg::ADDR_W-1:0] regAddr,
	input  wire logic [sim_pkg::DATA_W-1:0] regWrData,
	input  wire logic                       regWr,
	input  wire logic                       regRd,
	output logic      [sim_pkg::DATA_W-1:0] regRdData,
	// Connector inputs, closed contact reads 1
	input  wire logic                       doorChanA,
	input  wire logic                       doorChanB,
	input  wire logic                       stopContactA,
	input  wire logic                       stopContactB,
	input  wire logic                       latchRelease,
	input  wire logic                       teachSelect,
	input  wire logic                       pendantPresent,
	input  wire logic                       bypassPlug,
	// Safety outputs
	output logic                            programHold,
	output logic                            powerProhibit,
	output logic                            stopIndicator,
	output logic                            criticalError,
	output logic                            irq
);

	// ***************************************************************
	// Input synchronisers
	// ***************************************************************

	logic [sim_pkg::PIN_W-1:0] pinRaw;
	logic [sim_pkg::PIN_W-1:0] pinMeta_q;
	logic [sim_pkg::PIN_W-1:0] pinSync_q;

	// Gather the connector pins in package order
	assign pinRaw[sim_pkg::PIN_DOORA] = doorChanA;
	assign pinRaw[sim_pkg::PIN_DOORB] = doorChanB;
	assign pinRaw[sim_pkg::PIN_STOPA] = stopContactA;
	assign pinRaw[sim_pkg::PIN_STOPB] = stopContactB;
	assign pinRaw[sim_pkg::PIN_REL]   = latchRelease;
	assign pinRaw[sim_pkg::PIN_TEACH] = teachSelect;
	assign pinRaw[sim_pkg::PIN_PEND]  = pendantPresent;
	assign pinRaw[sim_pkg::PIN_BYP]   = bypassPlug;

	// Two flops per pin; the first is read only by the second
	for (genvar i = 0; i < sim_pkg::PIN_W; i++) begin : g_sync
		always_ff @(posedge core_clk or negedge arst_n) begin
			if (!arst_n) begin
				pinMeta_q[i] <= 1'b0;
				pinSync_q[i] <= 1'b0;
			end else begin
				pinMeta_q[i] <= pinRaw[i];
				pinSync_q[i] <= pinMeta_q[i];
			end
		end
	end

	// ***************************************************************
	// Decoded conditions
	// ***************************************************************

	logic doorOpen;
	logic stopPressed;
	logic pendantLost;
	logic relClosed;
	logic relPrev_q;
	logic relRise;
	logic teachOn;

	// Reset value 0 reads as open, so nothing is trusted until seen closed
	assign doorOpen    = ~(pinSync_q[sim_pkg::PIN_DOORA] & pinSync_q[sim_pkg::PIN_DOORB]);
	assign stopPressed = ~(pinSync_q[sim_pkg::PIN_STOPA] & pinSync_q[sim_pkg::PIN_STOPB]);
	assign pendantLost = ~pinSync_q[sim_pkg::PIN_PEND] & ~pinSync_q[sim_pkg::PIN_BYP];
	assign relClosed   = pinSync_q[sim_pkg::PIN_REL];
	assign relRise     = relClosed & ~relPrev_q;
	assign teachOn     = pinSync_q[sim_pkg::PIN_TEACH];

	// Previous release level for edge detection
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			relPrev_q <= 1'b1;
		end else begin
			relPrev_q <= relClosed;
		end
	end

	// ***************************************************************
	// Discrepancy timers
	// ***************************************************************

	logic doorExp;
	logic stopExp;

	// Door pair
	sim_disc_timer #(
		.CYCLES (DISC_CYCLES),
		.CNT_W  (CNT_W)
	) u_doorTimer (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.chanA    (pinSync_q[sim_pkg::PIN_DOORA]),
		.chanB    (pinSync_q[sim_pkg::PIN_DOORB]),
		.expired  (doorExp)
	);

	// Stop contact pair; a healthy double contact never trips it
	sim_disc_timer #(
		.CYCLES (DISC_CYCLES),
		.CNT_W  (CNT_W)
	) u_stopTimer (
		.core_clk (core_clk),
		.arst_n   (arst_n),
		.chanA    (pinSync_q[sim_pkg::PIN_STOPA]),
		.chanB    (pinSync_q[sim_pkg::PIN_STOPB]),
		.expired  (stopExp)
	);

	// ***************************************************************
	// Latches and stop state
	// ***************************************************************

	logic                  doorLatch_q;
	logic                  doorLatch_d;
	logic                  teachLatch_q;
	logic                  teachLatch_d;
	logic                  teachAck_q;
	logic                  teachAck_d;
	logic                  critErr_q;
	logic                  critErr_d;
	logic                  resetCmd;
	logic                  stopCond;
	sim_pkg::sim_stop_type stop_q;
	sim_pkg::sim_stop_type stop_d;

	// Reset command is a write of the control register
	assign resetCmd = regWr & (regAddr == sim_pkg::OFS_CTRL) & regWrData[sim_pkg::CTRL_RESET_BIT];

	// Door latch: set while door and release open, cleared by release after door closed
	assign doorLatch_d = (doorOpen & ~relClosed) ? 1'b1 :
		(relRise & ~doorOpen) ? 1'b0 : doorLatch_q;

	// Teach latch: held while teach selected, cleared by release in auto
	assign teachLatch_d = teachOn ? 1'b1 :
		relRise ? 1'b0 : teachLatch_q;

	// Release closing in teach mode acknowledges the mode change
	assign teachAck_d = teachOn & (teachAck_q | relRise);

	// Discrepancy sets win over a reset command in the same cycle
	assign critErr_d = (doorExp | stopExp) ? 1'b1 : (resetCmd ? 1'b0 : critErr_q);

	// Any live stop cause; an error must be reset like a pressed switch
	assign stopCond = stopPressed | pendantLost | critErr_q;

	// Stop state machine
	always_comb begin
		stop_d = stop_q;
		unique case (stop_q)
			sim_pkg::STOP_RUN: begin
				if (stopCond) begin
					stop_d = sim_pkg::STOP_HALT;
				end
			end
			sim_pkg::STOP_HALT: begin
				if (resetCmd & ~stopCond) begin
					stop_d = sim_pkg::STOP_RUN;
				end
			end
		endcase
	end

	// Latch and state registers; power-up starts halted for safety
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			doorLatch_q  <= 1'b1;
			teachLatch_q <= 1'b0;
			teachAck_q   <= 1'b0;
			critErr_q    <= 1'b0;
			stop_q       <= sim_pkg::STOP_HALT;
		end else begin
			doorLatch_q  <= doorLatch_d;
			teachLatch_q <= teachLatch_d;
			teachAck_q   <= teachAck_d;
			critErr_q    <= critErr_d;
			stop_q       <= stop_d;
		end
	end

	// ***************************************************************
	// Safety outputs
	// ***************************************************************

	logic holdNext;
	logic prohibitNext;

	// Door open always blocks power, even once teach is released
	assign holdNext     = doorOpen | doorLatch_d;
	assign prohibitNext = holdNext | (teachLatch_d & ~teachAck_d)
		| (stop_d == sim_pkg::STOP_HALT);

	// Output flops
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			programHold   <= 1'b1;
			powerProhibit <= 1'b1;
			stopIndicator <= 1'b1;
			criticalError <= 1'b0;
		end else begin
			programHold   <= holdNext;
			powerProhibit <= prohibitNext;
			stopIndicator <= (stop_d == sim_pkg::STOP_HALT);
			criticalError <= critErr_d;
		end
	end

	// ***************************************************************
	// Registers and interrupt
	// ***************************************************************

	logic [sim_pkg::EVT_W-1:0]  evt_q;
	logic [sim_pkg::EVT_W-1:0]  evt_d;
	logic [sim_pkg::EVT_W-1:0]  evtSet;
	logic [sim_pkg::EVT_W-1:0]  mask_q;
	logic [sim_pkg::EVT_W-1:0]  mask_d;
	logic [sim_pkg::STAT_W-1:0] status;
	logic [sim_pkg::DATA_W-1:0] rdMux;
	logic                       evtRead;

	// Rising edges of the watched conditions
	assign evtSet[sim_pkg::EV_DOOR_DISC]   = doorExp & ~critErr_q;
	assign evtSet[sim_pkg::EV_STOP_DISC]   = stopExp & ~critErr_q;
	assign evtSet[sim_pkg::EV_STOP_ENTER]  = (stop_q == sim_pkg::STOP_RUN) & (stop_d == sim_pkg::STOP_HALT);
	assign evtSet[sim_pkg::EV_DOOR_LATCH]  = doorLatch_d & ~doorLatch_q;
	assign evtSet[sim_pkg::EV_TEACH_LATCH] = teachLatch_d & ~teachLatch_q;

	// A read clears; an event in the same cycle survives it
	assign evtRead = regRd & (regAddr == sim_pkg::OFS_EVENT);
	assign evt_d   = (evtRead ? '0 : evt_q) | evtSet;
	assign mask_d  = (regWr & (regAddr == sim_pkg::OFS_MASK)) ? regWrData[sim_pkg::EVT_W-1:0] : mask_q;

	// Live status word
	assign status[sim_pkg::ST_DOOR_OPEN]   = doorOpen;
	assign status[sim_pkg::ST_DOOR_LATCH]  = doorLatch_q;
	assign status[sim_pkg::ST_TEACH_LATCH] = teachLatch_q;
	assign status[sim_pkg::ST_PROHIBIT]    = powerProhibit;
	assign status[sim_pkg::ST_HOLD]        = programHold;
	assign status[sim_pkg::ST_STOP]        = (stop_q == sim_pkg::STOP_HALT);
	assign status[sim_pkg::ST_CRIT]        = critErr_q;
	assign status[sim_pkg::ST_TEACH_ACK]   = teachAck_q;

	// Read selection; unmapped addresses and idle cycles read zero
	assign rdMux = !regRd ? '0 :
		(regAddr == sim_pkg::OFS_STATUS) ? {{(sim_pkg::DATA_W-sim_pkg::STAT_W){1'b0}}, status} :
		(regAddr == sim_pkg::OFS_EVENT)  ? {{(sim_pkg::DATA_W-sim_pkg::EVT_W){1'b0}}, evt_q} :
		(regAddr == sim_pkg::OFS_MASK)   ? {{(sim_pkg::DATA_W-sim_pkg::EVT_W){1'b0}}, mask_q} : '0;

	// Register file, read data and interrupt
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			evt_q     <= '0;
			mask_q    <= sim_pkg::MASK_RESET;
			regRdData <= '0;
			irq       <= 1'b0;
		end else begin
			evt_q     <= evt_d;
			mask_q    <= mask_d;
			regRdData <= rdMux;
			irq       <= |(evt_d & mask_d);
		end
	end

	// ***************************************************************
	// Assertions
	// ***************************************************************

	default clocking cb @(posedge core_clk);
	endclocking
	default disable iff (!arst_n);

	a_door_disc_error: assert property (
		doorExp |=> criticalError && (stop_q == sim_pkg::STOP_RUN || stopIndicator))
		else $error("door discrepancy did not raise error");

	a_stop_disc_error: assert property (
		stopExp |=> criticalError ##1 stopIndicator)
		else $error("stop discrepancy did not raise error");

	a_door_hold: assert property (
		doorOpen |=> programHold && powerProhibit)
		else $error("door open without hold and prohibit");

	a_door_latch_keep: assert property (
		(doorOpen && !relClosed) ##1 (!doorOpen && !relRise) |=> doorLatch_q && programHold)
		else $error("door latch lost after door closed");

	a_teach_latch_set: assert property (
		teachOn |=> teachLatch_q)
		else $error("teach mode not latched");

	a_release_clears: assert property (
		(relRise && !doorOpen && !teachOn) |=> !doorLatch_q && !teachLatch_q)
		else $error("release did not clear latches");

	a_door_latch_clear: assert property (
		$fell(doorLatch_q) |-> $past(relRise && !doorOpen))
		else $error("door latch cleared without release");

	a_teach_latch_clear: assert property (
		$fell(teachLatch_q) |-> $past(relRise && !teachOn))
		else $error("teach latch cleared without auto and release");

	a_teach_ack: assert property (
		(teachOn && relRise) |=> teachAck_q)
		else $error("release did not acknowledge teach");

	a_power_door_open: assert property (
		(doorOpen && teachAck_q) |=> powerProhibit)
		else $error("power enabled with door open");

	a_stop_hold: assert property (
		$fell(stopIndicator) |-> $past(resetCmd && !stopCond))
		else $error("stop left without release and reset");

	a_stop_indicator: assert property (
		stopCond |=> stopIndicator ##1 (stopIndicator || $past(resetCmd)))
		else $error("indicator not lit in stop");

	a_open_inputs: assert property (
		(!pinSync_q[sim_pkg::PIN_STOPA] && !pinSync_q[sim_pkg::PIN_DOORA]) |=> powerProhibit && stopIndicator)
		else $error("open inputs allowed operation");

	a_pendant_stop: assert property (
		pendantLost |=> stopIndicator && (stop_q == sim_pkg::STOP_HALT))
		else $error("missing pendant did not stop");

endmodule

// [design/sim_pkg.sv]
/*
 * Constants shared by the safety interlock monitor: clock rate, discrepancy
 * time, register offsets, field positions and the stop state encoding.
 * Assumes a single 20 MHz core clock and a word-wide register port.
 */
package sim_pkg;

	// ***************************************************************
	// Timing
	// ***************************************************************
	localparam int CLK_HZ       = 20_000_000;
	localparam int DISC_TIME_MS = 2000;
	// Least time in whole cycles; the division truncates, nothing rounds up
	localparam int DISC_CYCLES  = (CLK_HZ / 1000 * DISC_TIME_MS + 0);
	localparam int CNT_W        = 26;

	// ***************************************************************
	// Register port
	// ***************************************************************
	localparam int ADDR_W = 4;
	localparam int DATA_W = 32;
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h4;
	localparam logic [ADDR_W-1:0] OFS_EVENT  = 4'h8;
	localparam logic [ADDR_W-1:0] OFS_MASK   = 4'hc;
	localparam int CTRL_RESET_BIT = 0;

	// Status register fields
	localparam int STAT_W          = 8;
	localparam int ST_DOOR_OPEN    = 0;
	localparam int ST_DOOR_LATCH   = 1;
	localparam int ST_TEACH_LATCH  = 2;
	localparam int ST_PROHIBIT     = 3;
	localparam int ST_HOLD         = 4;
	localparam int ST_STOP         = 5;
	localparam int ST_CRIT         = 6;
	localparam int ST_TEACH_ACK    = 7;

	// Event and mask register fields
	localparam int EVT_W           = 5;
	localparam int EV_DOOR_DISC    = 0;
	localparam int EV_STOP_DISC    = 1;
	localparam int EV_STOP_ENTER   = 2;
	localparam int EV_DOOR_LATCH   = 3;
	localparam int EV_TEACH_LATCH  = 4;
	localparam logic [EVT_W-1:0] MASK_RESET = 5'h00;

	// Connector input positions in the synchroniser vector
	localparam int PIN_W     = 8;
	localparam int PIN_DOORA = 0;
	localparam int PIN_DOORB = 1;
	localparam int PIN_STOPA = 2;
	localparam int PIN_STOPB = 3;
	localparam int PIN_REL   = 4;
	localparam int PIN_TEACH = 5;
	localparam int PIN_PEND  = 6;
	localparam int PIN_BYP   = 7;

	// Emergency stop state
	typedef enum logic [0:0] {
		STOP_RUN  = 1'b0,
		STOP_HALT = 1'b1
	} sim_stop_type;

endpackage

// [design/sim_disc_timer.sv]
/*
 * Discrepancy timer for one redundant channel pair.
 * Assumes both channels are already synchronised to core_clk.
 */
module sim_disc_timer #(
	parameter int CYCLES = sim_pkg::DISC_CYCLES,
	parameter int CNT_W  = sim_pkg::CNT_W
) (
	// Clock and reset
	input  wire logic core_clk,
	input  wire logic arst_n,
	// Channel pair
	input  wire logic chanA,
	input  wire logic chanB,
	// Result
	output logic      expired
);

	localparam logic [CNT_W-1:0] LAST = CNT_W'(CYCLES);

	// Refuse a counter too narrow for the time
	if (CYCLES < 2 || CYCLES >= (2 ** CNT_W)) begin : g_chk
		$error("sim_disc_timer: CYCLES does not fit CNT_W");
	end

	logic [CNT_W-1:0] cnt_q;
	logic [CNT_W-1:0] cnt_d;
	logic             agree;

	// Count disagreeing cycles, saturating at the limit
	assign agree = (chanA == chanB);
	assign cnt_d = agree ? '0 : ((cnt_q == LAST) ? cnt_q : cnt_q + 1'b1);

	// Counter and its flag
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_q   <= '0;
			expired <= 1'b0;
		end else begin
			cnt_q   <= cnt_d;
			expired <= ~agree & (cnt_d == LAST);
		end
	end

	a_timer_restart: assert property (@(posedge core_clk) disable iff (!arst_n)
		agree |=> (cnt_q == '0) && !expired)
		else $error("timer did not restart on agreement");

	a_timer_expiry: assert property (@(posedge core_clk) disable iff (!arst_n)
		(!agree && cnt_q == LAST - 1'b1) |=> expired)
		else $error("timer did not expire at the limit");

endmodule

// [sim/sim_switch_model.sv]
/*
 * Switch model: door interlock, stop button, latch release switch, mode key,
 * pendant and bypass plug as wired to the connector.
 * Assumes the bench steers it by command levels changed after a clock edge.
 */
module sim_switch_model (
	// Commands from the bench
	input  wire logic       doorShut,
	input  wire logic       stopPressed,
	input  wire logic       releaseShut,
	input  wire logic       teachMode,
	input  wire logic       pendantIn,
	input  wire logic       bypassIn,
	// Deliberate contact faults, one bit per channel
	input  wire logic [1:0] doorFault,
	input  wire logic [1:0] stopFault,
	// Connector pins, closed contact gives 1
	output logic            doorChanA,
	output logic            doorChanB,
	output logic            stopContactA,
	output logic            stopContactB,
	output logic            latchRelease,
	output logic            teachSelect,
	output logic            pendantPresent,
	output logic            bypassPlug
);
	timeunit 1ns;
	timeprecision 1ps;

	// Double contacts for door and stop only; a fault bit flips a single channel only
	assign doorChanA      = doorShut ^ doorFault[0];
	assign doorChanB      = doorShut ^ doorFault[1];
	assign stopContactA   = ~stopPressed ^ stopFault[0];
	assign stopContactB   = ~stopPressed ^ stopFault[1];
	assign latchRelease   = releaseShut;
	assign teachSelect    = teachMode;
	assign pendantPresent = pendantIn;
	assign bypassPlug     = bypassIn;
endmodule

// [sim/safety_interlock_monitor_test.sv]
/*
 * Self-checking bench for the safety interlock monitor and its switch model.
 * Assumes a 20 MHz core clock and a discrepancy time shortened to DISC cycles.
 */
module safety_interlock_monitor_test;
	timeunit 1ns;
	timeprecision 1ps;

	// ************************************************************
	// Signals
	// ************************************************************
	localparam int DISC = 16;
	logic                       core_clk;
	logic                       arst_n;
	logic [sim_pkg::ADDR_W-1:0] regAddr;
	logic [sim_pkg::DATA_W-1:0] regWrData;
	logic                       regWr;
	logic                       regRd;
	logic [sim_pkg::DATA_W-1:0] regRdData;
	logic                       doorShut, stopPressed, releaseShut, teachMode, pendantIn, bypassIn;
	logic [1:0]                 doorFault, stopFault;
	logic                       doorChanA, doorChanB, stopContactA, stopContactB;
	logic                       latchRelease, teachSelect, pendantPresent, bypassPlug;
	logic                       programHold, powerProhibit, stopIndicator, criticalError, irq;
	int                         numErrors;
	int                         checkCount;

	sim_switch_model sw (.doorShut(doorShut), .stopPressed(stopPressed), .releaseShut(releaseShut),
		.teachMode(teachMode), .pendantIn(pendantIn), .bypassIn(bypassIn), .doorFault(doorFault),
		.stopFault(stopFault), .doorChanA(doorChanA), .doorChanB(doorChanB), .stopContactA(stopContactA),
		.stopContactB(stopContactB), .latchRelease(latchRelease), .teachSelect(teachSelect),
		.pendantPresent(pendantPresent), .bypassPlug(bypassPlug));

	sim_interlock_top #(.DISC_CYCLES(DISC), .CNT_W(26)) dut (.core_clk(core_clk), .arst_n(arst_n),
		.regAddr(regAddr), .regWrData(regWrData), .regWr(regWr), .regRd(regRd), .regRdData(regRdData),
		.doorChanA(doorChanA), .doorChanB(doorChanB), .stopContactA(stopContactA),
		.stopContactB(stopContactB), .latchRelease(latchRelease), .teachSelect(teachSelect),
		.pendantPresent(pendantPresent), .bypassPlug(bypassPlug), .programHold(programHold),
		.powerProhibit(powerProhibit), .stopIndicator(stopIndicator), .criticalError(criticalError),
		.irq(irq));

	// ************************************************************
	// Tasks
	// ************************************************************
	function automatic logic [31:0] bitw(input int p);
		return 32'h1 << p;
	endfunction

	task automatic tick(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		regAddr <= a;
		regWrData <= d;
		regWr <= 1'b1;
		@(posedge core_clk);
		regWr <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe, so look mid-cycle
	task automatic rdChk(input string nm, input logic [3:0] a, input logic [31:0] exp, input logic [31:0] care);
		logic [31:0] got;
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge core_clk);
		regRd <= 1'b0;
		@(negedge core_clk);
		got = regRdData & care;
		checkCount++;
		if (got !== (exp & care)) begin
			numErrors++;
			$display("BAD %s expected %h seen %h", nm, exp & care, got);
		end
		@(posedge core_clk);
	endtask

	// Outputs in order hold, prohibit, stop, critical, irq
	task automatic chkOut(input logic [4:0] exp, input logic [4:0] care);
		logic [4:0] obs;
		@(negedge core_clk);
		obs = {programHold, powerProhibit, stopIndicator, criticalError, irq} & care;
		checkCount++;
		if (obs !== (exp & care)) begin
			numErrors++;
			$display("BAD outputs expected %b seen %b", exp & care, obs);
		end
		@(posedge core_clk);
	endtask

	// Latch clears act on the closing edge of the release switch
	task automatic cycleRelease;
		releaseShut <= 1'b0;
		tick(4);
		releaseShut <= 1'b1;
		tick(4);
	endtask

	task automatic resetCmd;
		wr(sim_pkg::OFS_CTRL, bitw(sim_pkg::CTRL_RESET_BIT));
		tick(1);
	endtask

	task automatic brk(input int p, input logic [1:0] f, input int n);
		if (p == 0) begin
			doorFault <= f;
		end else begin
			stopFault <= f;
		end
		tick(n);
		doorFault <= 2'b00;
		stopFault <= 2'b00;
		tick(4);
	endtask

	task automatic giveVerdict;
		$display("Comparisons %0d mismatches %0d", checkCount, numErrors);
		if (numErrors == 0 && checkCount > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	// ************************************************************
	// Clock, watchdog and main sequence
	// ************************************************************
	initial begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// Whole run is about four hundred cycles; over twenty times that means a hang
	initial begin
		repeat (10000) @(posedge core_clk);
		numErrors++;
		$display("BAD watchdog expected done seen hang");
		giveVerdict;
	end

	initial begin
		logic [4:0] m;
		int         d;
		{regAddr, regWrData, regWr, regRd, arst_n} = '0;
		{doorShut, stopPressed, releaseShut, teachMode, pendantIn, bypassIn} = '0;
		{doorFault, stopFault} = '0;
		numErrors = 0;
		checkCount = 0;
		void'($urandom(32'hf2a42f22));
		tick(5);
		arst_n <= 1'b1;
		tick(4);
		// Nothing connected: open contacts keep everything stopped
		chkOut(5'b11100, 5'b11111);
		rdChk("mask", sim_pkg::OFS_MASK, 32'h0, 32'hffffffff);
		rdChk("unmapped", 4'h2, 32'h0, 32'hffffffff);
		m = 5'($urandom);
		wr(sim_pkg::OFS_MASK, {27'h0, m});
		rdChk("mask", sim_pkg::OFS_MASK, {27'h0, m}, 32'hffffffff);
		rdChk("ctrl", sim_pkg::OFS_CTRL, 32'h0, 32'hffffffff);
		wr(sim_pkg::OFS_MASK, 32'h0);
		// Recovery from power-up
		doorShut <= 1'b1;
		pendantIn <= 1'b1;
		cycleRelease;
		resetCmd;
		chkOut(5'b00000, 5'b11111);
		// Door opened with release open, release closed before the door shuts
		releaseShut <= 1'b0;
		tick(4);
		doorShut <= 1'b0;
		tick(4);
		chkOut(5'b11000, 5'b11000);
		rdChk("status", sim_pkg::OFS_STATUS, bitw(0) | bitw(1), bitw(0) | bitw(1));
		releaseShut <= 1'b1;
		tick(4);
		doorShut <= 1'b1;
		tick(4);
		chkOut(5'b11000, 5'b11000);
		cycleRelease;
		chkOut(5'b00000, 5'b11111);
		// Teach mode latch, acknowledge and release
		teachMode <= 1'b1;
		tick(4);
		rdChk("teachLatch", sim_pkg::OFS_STATUS, bitw(2), bitw(2));
		cycleRelease;
		rdChk("teachAck", sim_pkg::OFS_STATUS, bitw(2) | bitw(7), bitw(2) | bitw(7));
		doorShut <= 1'b0;
		cycleRelease;
		chkOut(5'b01000, 5'b01000);
		doorShut <= 1'b1;
		teachMode <= 1'b0;
		tick(4);
		rdChk("teachLatch", sim_pkg::OFS_STATUS, bitw(2), bitw(2));
		cycleRelease;
		rdChk("teachLatch", sim_pkg::OFS_STATUS, 32'h0, bitw(2));
		chkOut(5'b00000, 5'b11111);
		// Stop switch with and without the interrupt mask
		wr(sim_pkg::OFS_MASK, bitw(sim_pkg::EV_STOP_ENTER));
		// Only the two door latch sets and the teach latch set are pending here
		rdChk("event", sim_pkg::OFS_EVENT, bitw(sim_pkg::EV_DOOR_LATCH) | bitw(sim_pkg::EV_TEACH_LATCH), 32'hffffffff);
		stopPressed <= 1'b1;
		tick(4);
		chkOut(5'b01101, 5'b01111);
		rdChk("event", sim_pkg::OFS_EVENT, bitw(2), bitw(2));
		chkOut(5'b00100, 5'b00101);
		resetCmd;
		chkOut(5'b00100, 5'b00100);
		stopPressed <= 1'b0;
		tick(8);
		chkOut(5'b00100, 5'b00100);
		resetCmd;
		chkOut(5'b00000, 5'b11111);
		wr(sim_pkg::OFS_MASK, 32'h0);
		stopPressed <= 1'b1;
		tick(4);
		chkOut(5'b00100, 5'b00101);
		stopPressed <= 1'b0;
		tick(4);
		resetCmd;
		chkOut(5'b00000, 5'b00100);
		// Pendant removed without a bypass plug
		pendantIn <= 1'b0;
		tick(4);
		chkOut(5'b00100, 5'b00100);
		bypassIn <= 1'b1;
		tick(4);
		resetCmd;
		chkOut(5'b00000, 5'b00100);
		pendantIn <= 1'b1;
		bypassIn <= 1'b0;
		// Channel disagreement: short runs, restarted runs, then a full run
		for (int p = 0; p < 2; p++) begin
			repeat (4) begin
				d = 1 + int'($urandom % (DISC - 4));
				brk(p, 2'($urandom % 2 + 1), d);
			end
			if (p == 0) begin
				doorFault <= 2'b01;
			end else begin
				stopFault <= 2'b10;
			end
			tick(DISC - 4);
			brk(p, 2'b00, 2);
			brk(p, 2'b01, DISC - 4);
			// A faulty stop contact also reads as a pressed switch, so leave that stop first
			resetCmd;
			chkOut(5'b00000, 5'b00110);
			brk(p, 2'b10, DISC + 4);
			chkOut(5'b00110, 5'b00110);
			rdChk("event", sim_pkg::OFS_EVENT, bitw(p), bitw(p));
			// The first command clears the error, which still stops that cycle; the second leaves the stop
			resetCmd;
			resetCmd;
			chkOut(5'b00000, 5'b00110);
		end
		giveVerdict;
	end
endmodule
